// ==== include/mdc_cfg.svh ====
// Constants for the mobile DDR bit-plane memory controller.
// Assumes a 125 MHz system clock; the memory clock is that clock divided by two.
`ifndef MDC_CFG_SVH
`define MDC_CFG_SVH

// ----------------------------------------------------------------------
// Geometry: 128 Mb as 4 banks x 4096 rows x 512 columns x 16 bits
// ----------------------------------------------------------------------
`define MDC_DQ_W 16
`define MDC_BANK_W 2
`define MDC_ROW_W 12
`define MDC_COL_W 9
`define MDC_REQ_ADDR_W 21
`define MDC_BURST_W 64
`define MDC_BANK_MSB 20
`define MDC_ROW_MSB 18
`define MDC_COL_MSB 6

// ----------------------------------------------------------------------
// Commands {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------------------------------------
`define MDC_CMD_NOP 4'h7
`define MDC_CMD_ACT 4'h3
`define MDC_CMD_RD 4'h5
`define MDC_CMD_WR 4'h4
`define MDC_CMD_PRE 4'h2
`define MDC_CMD_REF 4'h1
`define MDC_CMD_MRS 4'h0

// ----------------------------------------------------------------------
// Mode words: BL 4, sequential, CL 3; extended: full array, no TCSR
// ----------------------------------------------------------------------
`define MDC_MODE_WORD 12'h032
`define MDC_EXT_MODE_WORD 12'h000
`define MDC_MODE_BA 2'h0
`define MDC_EXT_MODE_BA 2'h2
`define MDC_ADDR_PRE_ALL 12'h400

// ----------------------------------------------------------------------
// Timing, in memory clocks unless given in ns
// ----------------------------------------------------------------------
`define MDC_SYS_PERIOD_NS 8
`define MDC_MEM_PERIOD_NS (2 * `MDC_SYS_PERIOD_NS)
`define MDC_NOM_MEM_MHZ_X100 13333
`define MDC_CAS_LAT 3
`define MDC_TRCD_CK 3
`define MDC_TRP_CK 3
`define MDC_TMRD_CK 2
`define MDC_BURST_LEN 4
`define MDC_WR_HOLD_CK 5
`define MDC_RD_HOLD_CK (`MDC_BURST_LEN / 2)
`define MDC_TREFI_NS 15625
`define MDC_TREFI_CK (`MDC_TREFI_NS / `MDC_MEM_PERIOD_NS)
`define MDC_TRFC_NS 80
`define MDC_TRFC_CK ((`MDC_TRFC_NS + `MDC_MEM_PERIOD_NS - 1) / `MDC_MEM_PERIOD_NS)
`define MDC_INIT_NS 200000
`define MDC_INIT_CK ((`MDC_INIT_NS + `MDC_MEM_PERIOD_NS - 1) / `MDC_MEM_PERIOD_NS)

// ----------------------------------------------------------------------
// Data strobe windows, in system cycles after a read or write command
// ----------------------------------------------------------------------
`define MDC_WR_LAST 4'h7
`define MDC_RD_FIRST 4'(2 * `MDC_CAS_LAT + 4)
`define MDC_RD_LAST 4'(2 * `MDC_CAS_LAT + 7)

`endif

// ==== include/mdc_pkg.sv ====
// Types for the mobile DDR bit-plane memory controller.
// Assumes mdc_cfg.svh is on the include path.
`include "mdc_cfg.svh"

package mdc_pkg;

   // -------------------------------------------------------------------
   // Controller states
   // -------------------------------------------------------------------
   typedef enum logic [9:0] {
      ST_INIT_WAIT = 10'h001,
      ST_INIT_PRE = 10'h002,
      ST_INIT_REF = 10'h004,
      ST_INIT_MRS = 10'h008,
      ST_INIT_EMRS = 10'h010,
      ST_IDLE = 10'h020,
      ST_ACTIVE = 10'h040,
      ST_RW = 10'h080,
      ST_PRE = 10'h100,
      ST_REFRESH = 10'h200
   } mdc_state_type;

   // -------------------------------------------------------------------
   // All controller state
   // -------------------------------------------------------------------
   typedef struct packed {
      mdc_state_type state;
      logic [13:0] cnt;
      logic [9:0] refi;
      logic ref_pend;
      logic ref_second;
      logic turn;
      logic init_done;
      logic is_wr;
      logic [`MDC_REQ_ADDR_W-1:0] addr_q;
      logic [`MDC_BURST_W-1:0] wdata;
      logic [3:0] wcyc;
      logic [3:0] rcyc;
      logic dqs_seen;
      logic [`MDC_BURST_W-1:0] rdata;
      logic rd_valid;
      logic ck;
      logic ck_n;
      logic cke;
      logic [3:0] cmd;
      logic [`MDC_BANK_W-1:0] ba;
      logic [`MDC_ROW_W-1:0] maddr;
      logic [`MDC_DQ_W-1:0] dq_o;
      logic dq_oe;
      logic dqs_o;
      logic dqs_oe;
      logic wr_rdy;
      logic rd_rdy;
   } mdc_regs_type;

endpackage : mdc_pkg

// ==== logic/mdc_sync.sv ====
// Two-stage synchroniser for pins read by the memory controller.
// Assumes the inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none

module mdc_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } mdc_sync_regs_type;

   mdc_sync_regs_type r;
   mdc_sync_regs_type n;

   // -------------------------------------------------------------------
   // First stage feeds only the second
   // -------------------------------------------------------------------
   always_comb begin
      n = r;
      n.s1 = d;
      n.s2 = r.s1;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign q = r.s2;

endmodule : mdc_sync

`default_nettype wire

// ==== logic/mdc_ctrl.sv ====
// Mobile DDR SDRAM controller holding bit-plane frame data.
// Assumes one x16 four-bank part on the pins and same-clock request ports.
//
// Contract
// [R1] All frame data goes to external mobile DDR using its command set and DDR data.
// [R2] Addresses span only 128 Mb, so the top row address bit is never driven.
// [R3] The data path is 16 bits over four banks, chosen by a 2-bit bank on every command.
// [R4] CAS latency is 3, with 3 clocks from activate to access and from precharge on.
// [R5] The mode register sets burst length 4, each access moving four beats in two clocks.
// [R6] The memory interface is 16 bits at a fixed memory clock, whatever the part's rating.
// [R7] Partial-array and temperature-compensated self refresh stay off; all rows refresh.
`timescale 1ns/1ps
`default_nettype none
`include "mdc_cfg.svh"

module mdc_ctrl
   import mdc_pkg::*;
#(
   parameter int INIT_TICKS = `MDC_INIT_CK
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic wr_req_valid,
   output logic wr_req_ready,
   input wire logic [`MDC_REQ_ADDR_W-1:0] wr_req_addr,
   input wire logic [`MDC_BURST_W-1:0] wr_req_data,
   input wire logic rd_req_valid,
   output logic rd_req_ready,
   input wire logic [`MDC_REQ_ADDR_W-1:0] rd_req_addr,
   output logic [`MDC_BURST_W-1:0] rd_data,
   output logic rd_data_valid,
   output logic init_done,
   output logic mem_ck,
   output logic mem_ck_n,
   output logic mem_cke,
   output logic mem_cs_n,
   output logic mem_ras_n,
   output logic mem_cas_n,
   output logic mem_we_n,
   output logic [`MDC_BANK_W-1:0] mem_ba,
   output logic [`MDC_ROW_W-1:0] mem_addr,
   input wire logic [`MDC_DQ_W-1:0] mem_dq_i,
   output logic [`MDC_DQ_W-1:0] mem_dq_o,
   output logic mem_dq_oe,
   input wire logic mem_dqs_i,
   output logic mem_dqs_o,
   output logic mem_dqs_oe
);

   mdc_regs_type r;
   mdc_regs_type n;
   logic tick;
   logic [`MDC_DQ_W-1:0] rx_dq;
   logic rx_dqs;
   logic [`MDC_COL_W-1:0] col;

   // -------------------------------------------------------------------
   // Read pins cross into sys_clk before use
   // -------------------------------------------------------------------
   mdc_sync #(.W(`MDC_DQ_W + 1)) u_rx_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .d({mem_dqs_i, mem_dq_i}),
      .q({rx_dqs, rx_dq})
   );

   // Burst-aligned column: low two bits stay zero for a four-beat burst
   assign col = {r.addr_q[`MDC_COL_MSB:0], 2'h0};   // [R5]

   // -------------------------------------------------------------------
   // Next-state logic; commands move only on a falling memory clock
   // -------------------------------------------------------------------
   always_comb begin
      n = r;
      tick = r.ck;
      n.ck = ~r.ck;                                   // [R6]
      n.ck_n = r.ck;
      n.rd_valid = 1'b0;
      // Beat counters run at the system rate, one beat per memory edge
      if (r.wcyc != 4'h0) begin
         n.wcyc = (r.wcyc == `MDC_WR_LAST) ? 4'h0 : r.wcyc + 4'h1;
      end
      if (r.rcyc != 4'h0) begin
         n.rcyc = (r.rcyc == `MDC_RD_LAST) ? 4'h0 : r.rcyc + 4'h1;
      end
      // Read capture: four synchronised beats, first beat lands lowest
      if (r.rcyc >= `MDC_RD_FIRST && r.rcyc <= `MDC_RD_LAST) begin
         n.rdata = {rx_dq, r.rdata[`MDC_BURST_W-1:`MDC_DQ_W]};   // [R1]
         n.dqs_seen = r.dqs_seen | rx_dqs;
         n.rd_valid = (r.rcyc == `MDC_RD_LAST) && (r.dqs_seen | rx_dqs);
      end
      if (tick) begin
         n.cmd = `MDC_CMD_NOP;
         if (r.cnt != 14'h0000) begin
            n.cnt = r.cnt - 14'h0001;
         end
         // Whole-array refresh timer; a new request beats the clear below
         if (r.init_done) begin
            if (r.refi == 10'(`MDC_TREFI_CK - 1)) begin
               n.refi = 10'h000;
               n.ref_pend = 1'b1;                     // [R7]
            end else begin
               n.refi = r.refi + 10'h001;
            end
         end
         case (r.state)
            ST_INIT_WAIT: begin
               if (r.cnt == 14'h0000) begin
                  n.cke = 1'b1;
                  n.cmd = `MDC_CMD_PRE;
                  n.maddr = `MDC_ADDR_PRE_ALL;
                  n.cnt = 14'(`MDC_TRP_CK - 1);
                  n.state = ST_INIT_PRE;
               end
            end
            ST_INIT_PRE, ST_INIT_REF: begin
               if (r.cnt == 14'h0000) begin
                  n.cnt = 14'(`MDC_TRFC_CK - 1);
                  n.cmd = `MDC_CMD_REF;
                  n.state = ST_INIT_REF;
                  if (r.state == ST_INIT_REF) begin
                     n.ref_second = 1'b1;
                  end
                  if (r.state == ST_INIT_REF && r.ref_second) begin
                     n.cmd = `MDC_CMD_MRS;
                     n.ba = `MDC_MODE_BA;
                     n.maddr = `MDC_MODE_WORD;        // [R4] [R5]
                     n.cnt = 14'(`MDC_TMRD_CK - 1);
                     n.state = ST_INIT_MRS;
                  end
               end
            end
            ST_INIT_MRS: begin
               if (r.cnt == 14'h0000) begin
                  n.cmd = `MDC_CMD_MRS;
                  n.ba = `MDC_EXT_MODE_BA;
                  n.maddr = `MDC_EXT_MODE_WORD;       // [R7]
                  n.cnt = 14'(`MDC_TMRD_CK - 1);
                  n.state = ST_INIT_EMRS;
               end
            end
            ST_INIT_EMRS: begin
               if (r.cnt == 14'h0000) begin
                  n.init_done = 1'b1;
                  n.state = ST_IDLE;
               end
            end
            ST_IDLE: begin
               n.turn = ~r.turn;
               if (r.ref_pend) begin
                  n.ref_pend = n.ref_pend & (r.refi == 10'(`MDC_TREFI_CK - 1));
                  n.cmd = `MDC_CMD_REF;
                  n.cnt = 14'(`MDC_TRFC_CK - 1);
                  n.state = ST_REFRESH;
               end else if ((r.wr_rdy && wr_req_valid) || (r.rd_rdy && rd_req_valid)) begin
                  n.is_wr = r.wr_rdy;
                  n.addr_q = r.wr_rdy ? wr_req_addr : rd_req_addr;
                  n.wdata = r.wr_rdy ? wr_req_data : r.wdata;
                  n.cmd = `MDC_CMD_ACT;
                  n.ba = n.addr_q[`MDC_BANK_MSB -: `MDC_BANK_W];        // [R3]
                  n.maddr = n.addr_q[`MDC_ROW_MSB -: `MDC_ROW_W];       // [R2]
                  n.cnt = 14'(`MDC_TRCD_CK - 1);
                  n.state = ST_ACTIVE;
               end
            end
            ST_ACTIVE: begin
               if (r.cnt == 14'h0000) begin
                  n.cmd = r.is_wr ? `MDC_CMD_WR : `MDC_CMD_RD;          // [R4]
                  n.maddr = {{(`MDC_ROW_W - `MDC_COL_W){1'b0}}, col};
                  n.wcyc = r.is_wr ? 4'h1 : 4'h0;
                  n.rcyc = r.is_wr ? 4'h0 : 4'h1;
                  n.dqs_seen = 1'b0;
                  n.cnt = r.is_wr ? 14'(`MDC_WR_HOLD_CK - 1) : 14'(`MDC_RD_HOLD_CK - 1);
                  n.state = ST_RW;
               end
            end
            ST_RW: begin
               if (r.cnt == 14'h0000) begin
                  n.cmd = `MDC_CMD_PRE;                                 // [R3]
                  n.maddr = {`MDC_ROW_W{1'b0}};
                  n.cnt = 14'(`MDC_TRP_CK - 1);
                  n.state = ST_PRE;
               end
            end
            ST_PRE, ST_REFRESH: begin
               if (r.cnt == 14'h0000) begin
                  n.state = ST_IDLE;                                    // [R4]
               end
            end
            default: begin
               n.state = ST_INIT_WAIT;
            end
         endcase
      end
      // Write strobe: two-cycle preamble, four beats, then released
      n.dqs_oe = (n.wcyc >= 4'h2);
      n.dqs_o = (n.wcyc == 4'h4) || (n.wcyc == 4'h6);
      n.dq_oe = (n.wcyc >= 4'h4);
      case (n.wcyc)
         4'h4: n.dq_o = r.wdata[15:0];
         4'h5: n.dq_o = r.wdata[31:16];
         4'h6: n.dq_o = r.wdata[47:32];
         4'h7: n.dq_o = r.wdata[63:48];
         default: n.dq_o = {`MDC_DQ_W{1'b0}};
      endcase
      // Ready is offered only in the tick cycle itself, one side per slot
      n.wr_rdy = (n.state == ST_IDLE) && n.ck && !n.ref_pend && !n.turn;
      n.rd_rdy = (n.state == ST_IDLE) && n.ck && !n.ref_pend && n.turn;
   end

   // -------------------------------------------------------------------
   // State register; CKE low and NOP while the part powers up
   // -------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         r <= '0;
         r.state <= ST_INIT_WAIT;
         r.cmd <= `MDC_CMD_NOP;
         r.cnt <= 14'(INIT_TICKS - 1);
      end else begin
         r <= n;
      end
   end

   // -------------------------------------------------------------------
   // Outputs, all straight from the state register
   // -------------------------------------------------------------------
   assign wr_req_ready = r.wr_rdy;
   assign rd_req_ready = r.rd_rdy;
   assign rd_data = r.rdata;
   assign rd_data_valid = r.rd_valid;
   assign init_done = r.init_done;
   assign mem_ck = r.ck;
   assign mem_ck_n = r.ck_n;
   assign mem_cke = r.cke;
   assign {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = r.cmd;
   assign mem_ba = r.ba;
   assign mem_addr = r.maddr;
   assign mem_dq_o = r.dq_o;
   assign mem_dq_oe = r.dq_oe;
   assign mem_dqs_o = r.dqs_o;
   assign mem_dqs_oe = r.dqs_oe;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   a_cmd_held_clock: assert property ((r.cmd != $past(r.cmd)) |-> !r.ck) // [R1]
      else $error("command changed off the falling memory clock");
   a_row_fits_space: assert property ((r.cmd == `MDC_CMD_ACT) |-> // [R2]
      (r.maddr == r.addr_q[`MDC_ROW_MSB -: `MDC_ROW_W]))
      else $error("activate row differs from request row");
   a_bank_on_access: assert property ( // [R3] [R4]
      ((r.cmd == `MDC_CMD_RD) || (r.cmd == `MDC_CMD_WR)) && $changed(r.cmd) |->
      ($past(r.cmd, 6) == `MDC_CMD_ACT) && $stable(r.ba))
      else $error("access not three clocks after activate in same bank");
   a_precharge_gap: assert property ((r.cmd == `MDC_CMD_ACT) && $changed(r.cmd) |-> // [R4]
      ($past(r.cmd, 2) != `MDC_CMD_PRE) && ($past(r.cmd, 4) != `MDC_CMD_PRE))
      else $error("activate within three clocks of precharge");
   a_mode_word: assert property ((r.cmd == `MDC_CMD_MRS) && (r.ba == `MDC_MODE_BA) |-> // [R5]
      (r.maddr == `MDC_MODE_WORD))
      else $error("mode register not burst 4 latency 3");
   a_write_burst: assert property ($rose(r.dqs_oe) |-> // [R5]
      (r.dqs_oe && !r.dq_oe)[*2] ##1 (r.dq_oe && r.dqs_o) ##1 r.dq_oe[*3] ##1 !r.dqs_oe)
      else $error("write burst not four beats");
   a_clock_toggles: assert property (!$past(sys_rst) |-> (r.ck != $past(r.ck)) // [R6]
      && (r.ck_n == $past(r.ck)))
      else $error("memory clock did not toggle");
   a_ext_mode_word: assert property ((r.cmd == `MDC_CMD_MRS) && // [R7]
      (r.ba == `MDC_EXT_MODE_BA) |-> (r.maddr == `MDC_EXT_MODE_WORD))
      else $error("extended mode register not full array");

endmodule : mdc_ctrl

`default_nettype wire

// ==== tb/mdc_mem_model.sv ====
// Behavioural x16 four-bank mobile DDR part facing the bit-plane controller.
// Assumes sys_clk is the controller clock; resolves the DQ and DQS wires itself.
`timescale 1ns/1ps
`default_nettype none

module mdc_mem_model (
   input wire logic sys_clk,
   input wire logic mem_ck,
   input wire logic [3:0] cmd,
   input wire logic [1:0] ba,
   input wire logic [11:0] addr,
   input wire logic [15:0] dq_o,
   input wire logic dq_oe,
   input wire logic dqs_o,
   input wire logic dqs_oe,
   output logic [15:0] dq_w,
   output logic dqs_w,
   output logic [11:0] mode_word,
   output logic [11:0] ext_word,
   output logic [1:0] act_ba,
   output logic [11:0] act_row,
   output logic [8:0] col,
   output logic [7:0] rcd_gap,
   output logic [7:0] viol,
   output logic [7:0] refs
);
   logic [63:0] store [logic [22:0]];
   logic [11:0] rows [4];
   int act_t [4] = '{0, 0, 0, 0};
   int pre_t [4] = '{-9, -9, -9, -9};
   int mclk = 0;
   int rcnt = 0;
   int wcnt = 0;
   int wb = 0;
   logic [22:0] rkey, wkey;
   logic [63:0] rword, wword;
   logic [15:0] mdq = 16'h5a5a;
   logic mdqs = 1'b0;
   int gap_viol = 0;
   int beat_viol = 0;
   int ref_cnt = 0;

   // Each counter has a single writer; viol sums two of them and refs copies ref_cnt
   assign viol = 8'(gap_viol + beat_viol);
   assign refs = 8'(ref_cnt);

   // Controller wins while it drives; released lines keep changing, except DQS held low for the read preamble
   assign dq_w = dq_oe ? dq_o : mdq;
   assign dqs_w = dqs_oe ? dqs_o : mdqs;

   // -------------------------------------------------------------------
   // Commands, taken on the rising memory clock
   // -------------------------------------------------------------------
   always @(posedge mem_ck) begin
      mclk = mclk + 1;
      case (cmd)
         4'h3: begin
            if (mclk - pre_t[ba] < 3) gap_viol++;
            rows[ba] = addr;
            act_t[ba] = mclk;
            act_ba = ba;
            act_row = addr;
         end
         4'h4, 4'h5: begin
            rcd_gap = 8'(mclk - act_t[ba]);
            col = addr[8:0];
            if (cmd == 4'h5) begin
               rkey = {ba, rows[ba], addr[8:2]};
               rword = store.exists(rkey) ? store[rkey] : 64'hffff_ffff_ffff_ffff;
               rcnt = 1;
            end else begin
               wkey = {ba, rows[ba], addr[8:2]};
               wcnt = 1;
               wb = 0;
            end
         end
         4'h2: begin
            for (int b = 0; b < 4; b++) begin
               if (addr[10] || b == int'(ba)) pre_t[b] = mclk;
            end
         end
         4'h1: ref_cnt++;
         4'h0: begin
            if (ba == 2'h2) ext_word = addr;
            else mode_word = addr;
         end
         default: ;
      endcase
   end

   // -------------------------------------------------------------------
   // Data phases: CL3 read burst with preamble, four-beat write capture
   // -------------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rcnt >= 6 && rcnt <= 9) begin
         mdq <= rword[16*(rcnt-6) +: 16];
         mdqs <= (rcnt % 2 == 0);
      end else begin
         mdq <= ~mdq;
         mdqs <= (rcnt >= 4) ? 1'b0 : ~mdqs;
      end
      rcnt = (rcnt == 0 || rcnt == 9) ? 0 : rcnt + 1;
      if (wcnt != 0) begin
         wcnt = wcnt + 1;
         if (dq_oe === 1'b1 && wb < 4) begin
            if (dqs_o !== ~wb[0]) beat_viol++;
            wword[16*wb +: 16] = dq_o;
            wb = wb + 1;
         end else if (wb != 0 && wb < 4) begin
            beat_viol++;
         end
         if (wb == 4 || wcnt > 10) begin
            if (wb == 4) store[wkey] = wword;
            else beat_viol++;
            wcnt = 0;
         end
      end
   end
endmodule : mdc_mem_model

`default_nettype wire

// ==== tb/tb_mobile_ddr_bitplane_memory_ctrl.sv ====
// Self-checking bench for the mobile DDR bit-plane memory controller.
// Assumes mdc_cfg.svh on the include path and the memory model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "mdc_cfg.svh"

module tb_mobile_ddr_bitplane_memory_ctrl;
   logic sys_clk, sys_rst, wr_req_valid, wr_req_ready, rd_req_valid, rd_req_ready;
   logic rd_data_valid, init_done, mem_ck, mem_ck_n, mem_cke, mem_cs_n, mem_ras_n;
   logic mem_cas_n, mem_we_n, mem_dq_oe, dqs_w, mem_dqs_o, mem_dqs_oe;
   logic [20:0] wr_req_addr, rd_req_addr;
   logic [63:0] wr_req_data, rd_data;
   logic [1:0] mem_ba, act_ba;
   logic [11:0] mem_addr, mode_word, ext_word, act_row;
   logic [15:0] dq_w, mem_dq_o;
   logic [8:0] col;
   logic [7:0] rcd_gap, viol, refs;
   logic [20:0] addrs [12];
   logic [63:0] datas [12];
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;
   int n;
   integer seed;
   realtime t0;

   // Short power-up wait keeps the run brief
   mdc_ctrl #(.INIT_TICKS(4)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .wr_req_valid(wr_req_valid), .wr_req_ready(wr_req_ready), .wr_req_addr(wr_req_addr),
      .wr_req_data(wr_req_data), .rd_req_valid(rd_req_valid), .rd_req_ready(rd_req_ready),
      .rd_req_addr(rd_req_addr), .rd_data(rd_data), .rd_data_valid(rd_data_valid),
      .init_done(init_done), .mem_ck(mem_ck), .mem_ck_n(mem_ck_n), .mem_cke(mem_cke),
      .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
      .mem_ba(mem_ba), .mem_addr(mem_addr), .mem_dq_i(dq_w), .mem_dq_o(mem_dq_o),
      .mem_dq_oe(mem_dq_oe), .mem_dqs_i(dqs_w), .mem_dqs_o(mem_dqs_o),
      .mem_dqs_oe(mem_dqs_oe));

   mdc_mem_model mem (.sys_clk(sys_clk), .mem_ck(mem_ck),
      .cmd({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}), .ba(mem_ba), .addr(mem_addr),
      .dq_o(mem_dq_o), .dq_oe(mem_dq_oe), .dqs_o(mem_dqs_o), .dqs_oe(mem_dqs_oe),
      .dq_w(dq_w), .dqs_w(dqs_w), .mode_word(mode_word), .ext_word(ext_word),
      .act_ba(act_ba), .act_row(act_row), .col(col), .rcd_gap(rcd_gap), .viol(viol),
      .refs(refs));

   // -------------------------------------------------------------------
   // Clock, hang guard and shared tasks
   // -------------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Whole run needs about 3000 cycles; a hang stops well after that
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 10000) begin
         errors++;
         conclude();
      end
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic conclude;
      $display("Summary: %0d mismatches in %0d comparisons", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude

   // Request held until a ready pulse is sampled at the same edge
   task automatic do_write(input logic [20:0] a, input logic [63:0] d);
      int k;
      k = 0;
      wr_req_valid <= 1'b1;
      wr_req_addr <= a;
      wr_req_data <= d;
      do begin
         @(posedge sys_clk);
         k++;
      end while (wr_req_ready !== 1'b1 && k < 300);
      wr_req_valid <= 1'b0;
      check(64'(k < 300), 64'h1, "write taken");
   endtask : do_write

   task automatic do_read(input logic [20:0] a, input logic [63:0] exp);
      int k;
      k = 0;
      rd_req_valid <= 1'b1;
      rd_req_addr <= a;
      do begin
         @(posedge sys_clk);
         k++;
      end while (rd_req_ready !== 1'b1 && k < 300);
      rd_req_valid <= 1'b0;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (rd_data_valid !== 1'b1 && k < 40);
      check(64'(k < 40), 64'h1, "read answered");
      check(rd_data, exp, "read data");
      @(posedge sys_clk);
      check(64'(rd_data_valid), 64'h0, "valid pulse");
   endtask : do_read

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial begin
      seed = 32'hd3cc;
      sys_rst = 1'b1;
      wr_req_valid = 1'b0;
      rd_req_valid = 1'b0;
      wr_req_addr = 21'h00_0000;
      rd_req_addr = 21'h00_0000;
      wr_req_data = 64'h0000_0000_0000_0000;
      repeat (6) @(posedge sys_clk);
      check(64'(init_done), 64'h0, "init during reset");
      check(64'(mem_cke), 64'h0, "cke during reset");
      check({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}, 64'h7, "nop in reset");
      sys_rst <= 1'b0;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (init_done !== 1'b1 && n < 2000);
      check(64'(init_done), 64'h1, "init done");
      check(64'(mem_cke), 64'h1, "cke after init");
      // Burst length 4 in bits 2:0, CAS latency 3 in bits 6:4
      check(mode_word, {5'h00, 3'd3, 1'b0, 3'd2}, "mode word");
      check(ext_word, 64'h0, "extended mode word");
      @(posedge mem_ck);
      t0 = $realtime;
      @(posedge mem_ck);
      check(64'(int'($realtime - t0)), 64'(2 * `MDC_SYS_PERIOD_NS), "ck period");
      @(posedge sys_clk);
      check(64'(mem_ck ^ mem_ck_n), 64'h1, "ck pair");
      // Corners first: lowest address, then top bank, top row, top column
      for (int i = 0; i < 12; i++) begin
         addrs[i] = (i == 0) ? 21'h00_0000 : (i == 1) ? 21'h1f_ffff :
                    {2'(i), 19'($random(seed))};
         datas[i] = {$random(seed), $random(seed)};
         do_write(addrs[i], datas[i]);
         repeat (10) @(posedge sys_clk);
         check(act_ba, addrs[i][20:19], "bank");
         check(act_row, addrs[i][18:7], "row");
         check(col, {addrs[i][6:0], 2'b00}, "column");
         check(rcd_gap, 64'h3, "act to write");
      end
      // Idle long enough for a refresh to run before the data is read back
      repeat (2100) @(posedge sys_clk);
      check(64'(refs != 8'h00), 64'h1, "refresh seen");
      for (int i = 11; i >= 0; i--) begin
         do_read(addrs[i], datas[i]);
      end
      check(rcd_gap, 64'h3, "act to read");
      // Overwrite then read straight back: the read must see the new burst
      do_write(addrs[1], ~datas[1]);
      do_read(addrs[1], ~datas[1]);
      check(viol, 64'h0, "memory timing");
      conclude();
   end
endmodule : tb_mobile_ddr_bitplane_memory_ctrl

`default_nettype wire
